//--- core/jtmap_bsr.sv
// Boundary-scan register with shift stage and falling-edge update latch
module jtmap_bsr
    import jtmap_pkg::*;
#(
    parameter int LEN = BSR_LEN
) (
    input wire logic tck,
    input wire logic reset_n,
    input wire logic capture,
    input wire logic shift,
    input wire logic update,
    input wire logic tdi,
    input wire logic [PIN_OUT_N-1:0] cap_out,
    input wire logic [PIN_IN_N-1:0] cap_in,
    output logic tdo_bit,
    output logic [PIN_OUT_N-1:0] upd_out
);

    logic [LEN-1:0] chain;
    logic [LEN-1:0] cap_vec;

    if (LEN < BSR_IN_BASE + PIN_IN_N) begin : g_bad_len
        $error("jtmap_bsr: LEN too short for the pin cells");
    end

    // ----------------------------------------
    // Capture map, reserved cells read zero
    // ----------------------------------------
    for (genvar i = 0; i < LEN; i++) begin : g_cell
        if (i >= BSR_OUT_BASE && i < BSR_OUT_BASE + PIN_OUT_N) begin : g_out
            assign cap_vec[i] = cap_out[i-BSR_OUT_BASE];
        end else if (i >= BSR_IN_BASE && i < BSR_IN_BASE + PIN_IN_N) begin : g_in
            assign cap_vec[i] = cap_in[i-BSR_IN_BASE];
        end else begin : g_rsv
            assign cap_vec[i] = 1'b0;
        end
    end

    always_ff @(posedge tck or negedge reset_n) begin
        if (!reset_n) begin
            chain <= '0;
        end else if (capture) begin
            chain <= cap_vec;
        end else if (shift) begin
            chain <= {tdi, chain[LEN-1:1]};
        end
    end

    assign tdo_bit = chain[0];

    // ----------------------------------------
    // Update latch on the falling edge
    // ----------------------------------------
    always_ff @(negedge tck or negedge reset_n) begin
        if (!reset_n) begin
            upd_out <= '0;
        end else if (update) begin
            upd_out <= chain[BSR_OUT_BASE +: PIN_OUT_N];
        end
    end

endmodule

//--- core/jtmap_pkg.sv
// Shared constants and types for the test access port with memory access
package jtmap_pkg;

    // ----------------------------------------
    // Instruction register
    // ----------------------------------------
    localparam int IR_W = 5;
    localparam logic [4:0] IR_CAPTURE_VALUE = 5'h01;
    localparam logic [4:0] INSN_IDCODE = 5'h00;
    localparam logic [4:0] INSN_SAMPLE = 5'h01;
    localparam logic [4:0] INSN_EXTEST = 5'h02;
    localparam logic [4:0] INSN_USERCODE = 5'h04;
    localparam logic [4:0] INSN_MEM_ADDR = 5'h08;
    localparam logic [4:0] INSN_MEM_READ = 5'h09;
    localparam logic [4:0] INSN_MEM_WRITE = 5'h0A;
    localparam logic [4:0] INSN_REBOOT = 5'h0C;
    localparam logic [4:0] INSN_SAVE = 5'h0D;
    localparam logic [4:0] INSN_BYPASS = 5'h1F;

    // ----------------------------------------
    // Data register sizes and layouts
    // ----------------------------------------
    localparam int MEM_W = 8;
    localparam int WORD_W = 32;
    localparam int BSR_LEN = 198;
    localparam int BSR_OUT_BASE = 148;
    localparam int BSR_IN_BASE = 183;
    localparam int PIN_OUT_N = 9;
    localparam int PIN_IN_N = 8;
    localparam int SLAVE_W = 7;
    // Identification fields, values arbitrary
    localparam logic [3:0] ID_VERSION = 4'h1;
    localparam logic [15:0] ID_DEVICE = 16'h5A5A;
    localparam logic [10:0] ID_MAKER = 11'h2A6;

    // ----------------------------------------
    // Controller states, Gray coded in declaration order
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h3,
        ST_CAP_DR = 4'h2,
        ST_SHIFT_DR = 4'h6,
        ST_EXIT1_DR = 4'h7,
        ST_PAUSE_DR = 4'h5,
        ST_EXIT2_DR = 4'h4,
        ST_UPD_DR = 4'hC,
        ST_SEL_IR = 4'hD,
        ST_CAP_IR = 4'hF,
        ST_SHIFT_IR = 4'hE,
        ST_EXIT1_IR = 4'hA,
        ST_PAUSE_IR = 4'hB,
        ST_EXIT2_IR = 4'h9,
        ST_UPD_IR = 4'h8
    } jtmap_state_t;

    typedef enum logic [2:0] {
        DR_BYPASS = 3'h0,
        DR_IDCODE = 3'h1,
        DR_USER = 3'h2,
        DR_ADDR = 3'h3,
        DR_READ = 3'h4,
        DR_WRITE = 3'h5,
        DR_BSR = 3'h6
    } jtmap_dr_t;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
    } jtmap_mem_req_t;

    typedef struct packed {
        logic [6:0] slave_addr;
        logic [7:0] fw_version;
        logic [7:0] rdata;
        logic [8:0] pin_out;
        logic [7:0] pin_in;
    } jtmap_observe_t;

endpackage

//--- core/jtmap_sync.sv
// Two flip-flop level synchroniser of configurable width
module jtmap_sync
    import jtmap_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    if (WIDTH < 1) begin : g_bad_width
        $error("jtmap_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

//--- core/jtmap_tap.sv
// Test access port with identification, boundary scan and memory access
// Operation
// - State changes on rising TCK, steered by TMS
// - Power-up: reset state, identification instruction loaded
// - Run-test/idle holds all registers unchanged
// - Select-DR: TMS low capture, high select-IR
// - Capture-DR loads selected register, then shift/exit1
// - Shift-DR moves selected register toward TDO
// - Exit1, pause, exit2 DR transitions
// - Update-DR falling edge copies to output latches
// - Select-IR: TMS low capture, high reset
// - Capture-IR loads fixed pattern into shifter
// - Shift-IR moves instruction shifter toward TDO
// - Exit1, pause, exit2 IR transitions
// - Update-IR falling edge makes current instruction
// - Five-bit instruction register, shifter plus latch
// - Code 11111 selects one-bit bypass
// - Code 00001 samples pins, allows preload
// - Code 00010 drives outputs from scan cells
// - Code 00000 selects 32-bit identification
// - Code 00100 selects user-code register
// - Codes 01000-01010 address, read, write memory
// - Code 01100 reboots, 01101 saves fault log
// - Host uses only one memory interface
// - Memory registers are eight bits wide
// - Reboot starts immediately on becoming current
// - Boundary register 198 cells, reserved capture zero
module jtmap_tap
    import jtmap_pkg::*;
#(
    parameter int BSR_CELLS = BSR_LEN
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [PIN_OUT_N-1:0] sys_pin_out,
    input wire logic [PIN_IN_N-1:0] pad_in,
    output logic [PIN_OUT_N-1:0] pad_out,
    input wire logic [7:0] fw_version,
    input wire logic [SLAVE_W-1:0] slave_addr,
    input wire logic [MEM_W-1:0] mem_rdata,
    input wire logic mem_rvalid,
    output jtmap_mem_req_t mem_req,
    output logic mem_wr,
    output logic mem_rd,
    output logic reboot,
    output logic fault_save
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    jtmap_state_t state;
    jtmap_state_t next_state;
    jtmap_dr_t dr_sel;
    jtmap_observe_t obs_async;
    jtmap_observe_t obs;
    logic [IR_W-1:0] ir_shift;
    logic [IR_W-1:0] ir_current;
    logic [WORD_W-1:0] dr_shift;
    logic bypass_bit;
    logic bsr_tdo;
    logic [PIN_OUT_N-1:0] bsr_upd;
    logic [MEM_W-1:0] addr_latch;
    logic [MEM_W-1:0] wdata_latch;
    logic extest_on;
    logic wr_toggle;
    logic rd_toggle;
    logic reboot_toggle;
    logic save_toggle;
    logic [MEM_W-1:0] rd_hold;
    logic [PIN_OUT_N+4:0] cross_async;
    logic [PIN_OUT_N+4:0] cross_sync;
    logic [3:0] toggle_prev;
    logic [3:0] toggle_edge;
    logic extest_sys;
    logic [PIN_OUT_N-1:0] bsr_upd_sys;

    if (BSR_CELLS < BSR_IN_BASE + PIN_IN_N) begin : g_bad_cells
        $error("jtmap_tap: BSR_CELLS too short for the pin cells");
    end

    // ----------------------------------------
    // Instruction decode
    // ----------------------------------------
    function automatic jtmap_dr_t decode_dr(input logic [IR_W-1:0] code);
        case (code)
            INSN_IDCODE: decode_dr = DR_IDCODE;
            INSN_SAMPLE: decode_dr = DR_BSR;
            INSN_EXTEST: decode_dr = DR_BSR;
            INSN_USERCODE: decode_dr = DR_USER;
            INSN_MEM_ADDR: decode_dr = DR_ADDR;
            INSN_MEM_READ: decode_dr = DR_READ;
            INSN_MEM_WRITE: decode_dr = DR_WRITE;
            INSN_BYPASS: decode_dr = DR_BYPASS;
            default: decode_dr = DR_BYPASS;
        endcase
    endfunction

    function automatic int dr_width(input jtmap_dr_t sel);
        case (sel)
            DR_IDCODE: dr_width = WORD_W;
            DR_USER: dr_width = WORD_W;
            DR_ADDR: dr_width = MEM_W;
            DR_READ: dr_width = MEM_W;
            DR_WRITE: dr_width = MEM_W;
            default: dr_width = 1;
        endcase
    endfunction

    assign dr_sel = decode_dr(ir_current);

    // ----------------------------------------
    // Controller next state
    // ----------------------------------------
    always_comb begin
        case (state)
            ST_RESET: next_state = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_IDLE;
            default: next_state = ST_RESET;
        endcase
    end

    always_ff @(posedge tck or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Instruction shifter and latch
    // ----------------------------------------
    always_ff @(posedge tck or negedge reset_n) begin
        if (!reset_n) begin
            ir_shift <= IR_CAPTURE_VALUE;
        end else if (state == ST_CAP_IR) begin
            ir_shift <= IR_CAPTURE_VALUE;
        end else if (state == ST_SHIFT_IR) begin
            ir_shift <= {tdi, ir_shift[IR_W-1:1]};
        end
    end

    always_ff @(negedge tck or negedge reset_n) begin
        if (!reset_n) begin
            ir_current <= INSN_IDCODE;
        end else if (state == ST_RESET) begin
            ir_current <= INSN_IDCODE;
        end else if (state == ST_UPD_IR) begin
            ir_current <= ir_shift;
        end
    end

    // ----------------------------------------
    // Pin, user and memory observation into the link domain
    // ----------------------------------------
    assign obs_async = '{
        slave_addr: slave_addr,
        fw_version: fw_version,
        rdata: rd_hold,
        pin_out: sys_pin_out,
        pin_in: pad_in
    };

    jtmap_sync #(
        .WIDTH($bits(jtmap_observe_t))
    ) u_obs_sync (
        .clock(tck),
        .reset_n(reset_n),
        .async_in(obs_async),
        .sync_out(obs)
    );

    // ----------------------------------------
    // Shared data shifter: bypass, identification, user code, memory
    // ----------------------------------------
    always_ff @(posedge tck or negedge reset_n) begin
        if (!reset_n) begin
            dr_shift <= '0;
            bypass_bit <= 1'b0;
        end else if (state == ST_CAP_DR) begin
            bypass_bit <= 1'b0;
            case (dr_sel)
                DR_IDCODE: dr_shift <= {ID_VERSION, ID_DEVICE, ID_MAKER, 1'b1};
                DR_USER: dr_shift <= {17'h00000, obs.slave_addr, obs.fw_version};
                DR_ADDR: dr_shift <= {24'h000000, addr_latch};
                DR_READ: dr_shift <= {24'h000000, obs.rdata};
                DR_WRITE: dr_shift <= {24'h000000, wdata_latch};
                default: dr_shift <= dr_shift;
            endcase
        end else if (state == ST_SHIFT_DR) begin
            bypass_bit <= tdi;
            if (dr_width(dr_sel) == WORD_W) begin
                dr_shift <= {tdi, dr_shift[WORD_W-1:1]};
            end else if (dr_width(dr_sel) == MEM_W) begin
                dr_shift <= {24'h000000, tdi, dr_shift[MEM_W-1:1]};
            end
        end
    end

    jtmap_bsr #(
        .LEN(BSR_CELLS)
    ) u_bsr (
        .tck(tck),
        .reset_n(reset_n),
        .capture(state == ST_CAP_DR && dr_sel == DR_BSR),
        .shift(state == ST_SHIFT_DR && dr_sel == DR_BSR),
        .update(state == ST_UPD_DR && dr_sel == DR_BSR),
        .tdi(tdi),
        .cap_out(obs.pin_out),
        .cap_in(obs.pin_in),
        .tdo_bit(bsr_tdo),
        .upd_out(bsr_upd)
    );

    // ----------------------------------------
    // Serial output, changed on the falling edge
    // ----------------------------------------
    always_ff @(negedge tck or negedge reset_n) begin
        if (!reset_n) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (state == ST_SHIFT_IR) begin
            tdo <= ir_shift[0];
            tdo_oe <= 1'b1;
        end else if (state == ST_SHIFT_DR) begin
            tdo_oe <= 1'b1;
            if (dr_sel == DR_BSR) begin
                tdo <= bsr_tdo;
            end else if (dr_sel == DR_BYPASS) begin
                tdo <= bypass_bit;
            end else begin
                tdo <= dr_shift[0];
            end
        end else begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end
    end

    // ----------------------------------------
    // Update latches and event toggles
    // ----------------------------------------
    always_ff @(negedge tck or negedge reset_n) begin
        if (!reset_n) begin
            addr_latch <= '0;
            wdata_latch <= '0;
            wr_toggle <= 1'b0;
            rd_toggle <= 1'b0;
        end else if (state == ST_UPD_DR) begin
            if (dr_sel == DR_ADDR) begin
                addr_latch <= dr_shift[MEM_W-1:0];
                rd_toggle <= ~rd_toggle;
            end
            if (dr_sel == DR_WRITE) begin
                wdata_latch <= dr_shift[MEM_W-1:0];
                wr_toggle <= ~wr_toggle;
            end
        end
    end

    always_ff @(negedge tck or negedge reset_n) begin
        if (!reset_n) begin
            reboot_toggle <= 1'b0;
            save_toggle <= 1'b0;
            extest_on <= 1'b0;
        end else if (state == ST_RESET) begin
            extest_on <= 1'b0;
        end else if (state == ST_UPD_IR) begin
            extest_on <= (ir_shift == INSN_EXTEST);
            if (ir_shift == INSN_REBOOT) begin
                reboot_toggle <= ~reboot_toggle;
            end
            if (ir_shift == INSN_SAVE) begin
                save_toggle <= ~save_toggle;
            end
        end
    end

    // ----------------------------------------
    // Crossing into the system clock
    // ----------------------------------------
    assign cross_async = {bsr_upd, extest_on, save_toggle, reboot_toggle, rd_toggle, wr_toggle};

    jtmap_sync #(
        .WIDTH(PIN_OUT_N + 5)
    ) u_sys_sync (
        .clock(clock),
        .reset_n(reset_n),
        .async_in(cross_async),
        .sync_out(cross_sync)
    );

    assign toggle_edge = cross_sync[3:0] ^ toggle_prev;
    assign extest_sys = cross_sync[4];
    assign bsr_upd_sys = cross_sync[PIN_OUT_N+4:5];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            toggle_prev <= '0;
            mem_wr <= 1'b0;
            mem_rd <= 1'b0;
            reboot <= 1'b0;
            fault_save <= 1'b0;
        end else begin
            toggle_prev <= cross_sync[3:0];
            mem_wr <= toggle_edge[0];
            mem_rd <= toggle_edge[1];
            reboot <= toggle_edge[2];
            fault_save <= toggle_edge[3];
        end
    end

    // ----------------------------------------
    // Memory request and read-data hold
    // ----------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mem_req <= '0;
        end else if (toggle_edge[0] || toggle_edge[1]) begin
            mem_req <= '{addr: addr_latch, wdata: wdata_latch};
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_hold <= '0;
        end else if (mem_rvalid) begin
            rd_hold <= mem_rdata;
        end
    end

    // ----------------------------------------
    // Pad outputs, taken from scan cells under external test
    // ----------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pad_out <= '0;
        end else if (extest_sys) begin
            pad_out <= bsr_upd_sys;
        end else begin
            pad_out <= sys_pin_out;
        end
    end

endmodule

//--- verification/jtmap_host.sv
// Scan host model driving the test port
module jtmap_host (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 100ps;
    // Sole memory path in use; the serial bus stays idle
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One test clock cycle, tdo taken at the rising edge
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #3;
        q = tdo;
        tck = 1'b1;
        #3;
        tck = 1'b0;
    endtask
    task automatic tap_reset();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
    // Scan from idle, optional pause after p bits, back to idle
    task automatic scan(input logic ir, input int n, input int p,
                        input logic [255:0] din, output logic [255:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir) begin
            step(1'b1, 1'b0, q);
        end
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1 || i == p - 1, din[i], q);
            dout[i] = q;
            if (i == p - 1 && p < n) begin
                step(1'b0, ~din[i], q);
                step(1'b0, ~din[i], q);
                step(1'b1, ~din[i], q);
                step(1'b0, ~din[i], q);
            end
        end
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        tdi = ~tdi;
    endtask
endmodule

//--- verification/jtmap_tap_assertions.sv
// Concurrent checks on the test access port pins
module jtmap_tap_assertions
    import jtmap_pkg::*;
#(
    parameter int BSR_CELLS = BSR_LEN
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire jtmap_mem_req_t mem_req,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic reboot,
    input wire logic fault_save
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----
    // Link side
    // ----
    property p_tdo_quiet;
        @(posedge tck) disable iff (!reset_n) !tdo_oe |-> !tdo;
    endproperty
    a_tdo_quiet: assert property (p_tdo_quiet) else $error("tdo active");
    property p_shift_exit;
        @(posedge tck) disable iff (!reset_n) tms |=> !tdo_oe;
    endproperty
    a_shift_exit: assert property (p_shift_exit) else $error("shift on tms high");
    property p_shift_entry;
        @(posedge tck) disable iff (!reset_n) $rose(tdo_oe) |-> !$past(tms);
    endproperty
    a_shift_entry: assert property (p_shift_entry) else $error("bad shift entry");
    // ----
    // System side
    // ----
    property p_wr_pulse;
        @(posedge clock) disable iff (!reset_n) mem_wr |=> !mem_wr;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse long");
    property p_rd_pulse;
        @(posedge clock) disable iff (!reset_n) mem_rd |-> !mem_wr ##1 !mem_rd;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse bad");
    property p_boot_pulse;
        @(posedge clock) disable iff (!reset_n) reboot |=> !reboot;
    endproperty
    a_boot_pulse: assert property (p_boot_pulse) else $error("reboot pulse long");
    property p_save_pulse;
        @(posedge clock) disable iff (!reset_n) $rose(fault_save) |=> $fell(fault_save);
    endproperty
    a_save_pulse: assert property (p_save_pulse) else $error("save pulse long");
    property p_req_change;
        @(posedge clock) disable iff (!reset_n) !$stable(mem_req) |-> mem_wr || mem_rd;
    endproperty
    a_req_change: assert property (p_req_change) else $error("request moved");
endmodule

//--- verification/tb_jtmap_tap.sv
// Self-checking bench for the test access port
module tb_jtmap_tap
    import jtmap_pkg::*;
    ();
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [4:0] code;
        int n;
        int p;
        logic [255:0] din;
        logic [255:0] exp;
    } jtmap_row_t;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe, mem_wr, mem_rd, reboot, fault_save;
    logic [PIN_OUT_N-1:0] sys_pin_out = 9'h0A5;
    logic [PIN_IN_N-1:0] pad_in = 8'h3C;
    logic [PIN_OUT_N-1:0] pad_out;
    logic [MEM_W-1:0] mem_rdata = 8'h00;
    logic mem_rvalid = 1'b0;
    jtmap_mem_req_t mem_req, wr_req;
    int mismatches = 0;
    int n_tests = 0;
    int n_wr = 0, n_rd = 0, n_boot = 0, n_save = 0;
    logic [255:0] dout, bsr;
    jtmap_row_t rows[5];
    jtmap_tap dut_u (.clock(clock), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .sys_pin_out(sys_pin_out), .pad_in(pad_in),
        .pad_out(pad_out), .fw_version(8'hC3), .slave_addr(7'h2A), .mem_rdata(mem_rdata),
        .mem_rvalid(mem_rvalid), .mem_req(mem_req), .mem_wr(mem_wr), .mem_rd(mem_rd),
        .reboot(reboot), .fault_save(fault_save));
    jtmap_host host_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    initial forever #20 clock = ~clock;
    // Memory answers a read one cycle later; event pulses counted
    always @(posedge clock) begin
        mem_rvalid <= mem_rd;
        mem_rdata <= ~mem_req.addr;
        if (mem_wr) begin
            wr_req <= mem_req;
        end
        n_wr <= n_wr + int'(mem_wr);
        n_rd <= n_rd + int'(mem_rd);
        n_boot <= n_boot + int'(reboot);
        n_save <= n_save + int'(fault_save);
    end
    task automatic check(input string what, input logic [255:0] exp, input logic [255:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic load(input logic [4:0] code);
        host_u.scan(1'b1, IR_W, 2, {251'h0, code}, dout);
        check("ir_capture", IR_CAPTURE_VALUE, dout);
        repeat (10) @(posedge clock);
    endtask
    task automatic dr(input int n, input int p, input logic [255:0] din);
        host_u.scan(1'b0, n, p, din, dout);
        repeat (10) @(posedge clock);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #2ms;
        mismatches++;
        end_of_test();
    end
    initial begin
        bsr = '0;
        bsr[BSR_OUT_BASE +: PIN_OUT_N] = sys_pin_out;
        bsr[BSR_IN_BASE +: PIN_IN_N] = pad_in;
        rows[0] = '{INSN_IDCODE, 32, 7, '0, {ID_VERSION, ID_DEVICE, ID_MAKER, 1'b1}};
        rows[1] = '{INSN_USERCODE, 32, 0, '0, 32'h00002AC3};
        rows[2] = '{INSN_BYPASS, 8, 3, 8'hA5, 8'h4A};
        rows[3] = '{5'h03, 8, 0, 8'hA5, 8'h4A};
        rows[4] = '{INSN_SAMPLE, BSR_LEN, 100, 256'(9'h0C3) << BSR_OUT_BASE, bsr};
        host_u.tap_reset();
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        host_u.tap_reset();
        repeat (4) @(posedge clock);
        check("pad_out", sys_pin_out, pad_out);
        dr(32, 0, '0);
        check("id_reset", rows[0].exp, dout);
        foreach (rows[i]) begin
            load(rows[i].code);
            dr(rows[i].n, rows[i].p, rows[i].din);
            check("dr_out", rows[i].exp, dout);
        end
        check("pad_sample", sys_pin_out, pad_out);
        load(INSN_EXTEST);
        check("pad_preload", 9'h0C3, pad_out);
        bsr[BSR_OUT_BASE +: PIN_OUT_N] = 9'h15A;
        dr(BSR_LEN, 0, bsr);
        check("bsr_extest", rows[4].exp, dout);
        check("pad_extest", 9'h15A, pad_out);
        host_u.tap_reset();
        repeat (10) @(posedge clock);
        check("pad_release", sys_pin_out, pad_out);
        load(INSN_MEM_ADDR);
        dr(MEM_W, 0, 8'h3C);
        check("mem_addr", 8'h3C, mem_req.addr);
        check("n_rd", 1, n_rd);
        load(INSN_MEM_READ);
        dr(MEM_W, 0, '0);
        check("mem_read", 8'hC3, dout);
        load(INSN_MEM_WRITE);
        dr(MEM_W, 4, 8'h96);
        check("wr_req", 16'h3C96, wr_req);
        check("n_wr", 1, n_wr);
        load(INSN_REBOOT);
        check("n_boot", 1, n_boot);
        load(INSN_SAVE);
        check("n_save", 1, n_save);
        end_of_test();
    end
endmodule
bind jtmap_tap jtmap_tap_assertions #(.BSR_CELLS(BSR_CELLS)) chk_u (.clock(clock),
    .reset_n(reset_n), .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe),
    .mem_req(mem_req), .mem_wr(mem_wr), .mem_rd(mem_rd), .reboot(reboot),
    .fault_save(fault_save));
